//--- src/pid_supervisor_pkg.sv
// Purpose: constants and types shared by the gain switch supervisor
// Assumes: percent values in 0.1 % steps, gains and times as stored codes
// Notes: register indices are word addresses on the plain register port
//
// Notes on behaviour
// - gain select terminal carries function code 43
// - terminal low uses set one, high set two
// - deviation below low threshold uses set one
// - deviation above high threshold uses set two
// - inside band, interpolate gains linearly by position
// - on start force output to startup value
// - regulate only after startup hold time elapses
// - integral attribute decoded digit by digit
// - separation on plus pause input freezes integrator
// - separation off ignores pause input completely
// - stop-at-limit option freezes integrator at limit
// - long low feedback raises feedback loss fault
// - zero loss threshold disables loss detection
// - stop operation selector: 0 halt, 1 continue
// - switch condition 0 none, 1 terminal, 2 auto
// - setpoint and feedback relative, deviation between
package pid_supervisor_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 5;
	localparam int DI_COUNT = 4;

	// timing: one base tick of 10 ms drives both timers
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int TICK_NS = 10_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
	localparam int LOSS_TICKS_PER_UNIT = 10;

	// register indices
	localparam logic [4:0] REG_PGAIN_ONE = 5'h00;
	localparam logic [4:0] REG_TI1 = 5'h01;
	localparam logic [4:0] REG_TD1 = 5'h02;
	localparam logic [4:0] REG_PGAIN_TWO = 5'h03;
	localparam logic [4:0] REG_TI2 = 5'h04;
	localparam logic [4:0] REG_TD2 = 5'h05;
	localparam logic [4:0] REG_SWITCH_COND = 5'h06;
	localparam logic [4:0] REG_THR_LOW = 5'h07;
	localparam logic [4:0] REG_THR_HIGH = 5'h08;
	localparam logic [4:0] REG_STARTUP_VALUE = 5'h09;
	localparam logic [4:0] REG_STARTUP_HOLD = 5'h0A;
	localparam logic [4:0] REG_INT_ATTR = 5'h0B;
	localparam logic [4:0] REG_LOSS_THR = 5'h0C;
	localparam logic [4:0] REG_LOSS_TIME = 5'h0D;
	localparam logic [4:0] REG_STOP_OP = 5'h0E;
	localparam logic [4:0] REG_STATE = 5'h0F;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h10;
	localparam logic [4:0] REG_IRQ_MASK = 5'h11;
	localparam logic [4:0] REG_DI_FUNC0 = 5'h12;

	// reset values
	localparam logic [15:0] RST_PGAIN_ONE = 16'h0190;
	localparam logic [15:0] RST_TI1 = 16'h0064;
	localparam logic [15:0] RST_TD1 = 16'h0000;
	localparam logic [15:0] RST_PGAIN_TWO = 16'h00C8;
	localparam logic [15:0] RST_TI2 = 16'h00C8;
	localparam logic [15:0] RST_TD2 = 16'h0000;
	localparam logic [1:0] RST_SWITCH_COND = 2'h0;
	localparam logic [15:0] RST_THR_LOW = 16'h00C8;
	localparam logic [15:0] RST_THR_HIGH = 16'h0320;
	localparam logic [15:0] RST_STARTUP_VALUE = 16'h0258;
	localparam logic [15:0] RST_STARTUP_HOLD = 16'h01F4;
	localparam logic [7:0] RST_INT_ATTR = 8'h00;
	localparam logic [15:0] RST_LOSS_THR = 16'h0000;
	localparam logic [15:0] RST_LOSS_TIME = 16'h0000;
	localparam logic RST_STOP_OP = 1'b1;

	// codes
	localparam logic [1:0] COND_NONE = 2'h0;
	localparam logic [1:0] COND_TERMINAL = 2'h1;
	localparam logic [1:0] COND_AUTO = 2'h2;
	localparam logic [7:0] FUNC_GAIN_SELECT = 8'h2B;
	localparam logic [7:0] FUNC_INTEGRAL_PAUSE = 8'h16;
	localparam logic [7:0] FAULT_FEEDBACK_LOSS = 8'h1F;
	localparam logic [7:0] DECIMAL_BASE = 8'h0A;

	// interrupt status bits
	localparam int IRQ_LOSS_BIT = 0;
	localparam int IRQ_HOLD_DONE_BIT = 1;
	localparam int IRQ_W = 2;

	typedef struct packed {
		logic [15:0] kp;
		logic [15:0] ti;
		logic [15:0] td;
	} gain_set_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_REGULATE = 2'b11
	} loop_state_t;

endpackage

//--- src/pid_gain_switch_supervisor.sv
// Purpose: gain set choice, startup hold, integral control, feedback loss
// Assumes: all inputs synchronous to clock; percent in 0.1 % steps
// Notes: the PID arithmetic sits outside and follows these outputs
`timescale 1ns/1ns
`default_nettype none
module pid_gain_switch_supervisor #(
	parameter int TICK_CYCLES = pid_supervisor_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [pid_supervisor_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pid_supervisor_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [pid_supervisor_pkg::DATA_W-1:0] regRdData,
	input wire logic [15:0] setpoint,
	input wire logic [15:0] feedback,
	input wire logic driveRunning,
	input wire logic driveStart,
	input wire logic outputAtLimit,
	input wire logic [pid_supervisor_pkg::DI_COUNT-1:0] diLevels,
	output pid_supervisor_pkg::gain_set_t activeGains,
	output logic outputForce,
	output logic [15:0] forcedOutput,
	output logic loopCompute,
	output logic integratorFreeze,
	output logic feedbackLossFault,
	output logic [7:0] faultCode,
	output logic irq
);
	import pid_supervisor_pkg::*;

	function automatic logic [15:0] lerp(input logic [15:0] a,
			input logic [15:0] b, input logic [15:0] pos,
			input logic [15:0] span);
		logic signed [17:0] diff;
		logic signed [35:0] prod;
		logic signed [35:0] quot;
		diff = $signed({2'b00, b}) - $signed({2'b00, a});
		// widen both factors first so the product cannot wrap
		prod = 36'(diff) * 36'($signed({2'b00, pos}));
		quot = prod / $signed({20'h00000, span});
		lerp = 16'(a + quot[15:0]);
	endfunction

	function automatic logic diActive(input logic [DI_COUNT-1:0] levels,
			input logic [DI_COUNT*8-1:0] funcs, input logic [7:0] code);
		diActive = 1'b0;
		for (int i = 0; i < DI_COUNT; i++) begin
			if (levels[i] && funcs[i*8 +: 8] == code) begin
				diActive = 1'b1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// configuration registers
	gain_set_t setOne_ff, nxt_setOne;
	gain_set_t setTwo_ff, nxt_setTwo;
	logic [1:0] switchCond_ff, nxt_switchCond;
	logic [15:0] thrLow_ff, nxt_thrLow;
	logic [15:0] thrHigh_ff, nxt_thrHigh;
	logic [15:0] startValue_ff, nxt_startValue;
	logic [15:0] holdTime_ff, nxt_holdTime;
	logic [7:0] intAttr_ff, nxt_intAttr;
	logic [15:0] lossThr_ff, nxt_lossThr;
	logic [15:0] lossTime_ff, nxt_lossTime;
	logic stopOp_ff, nxt_stopOp;
	logic [DI_COUNT*8-1:0] diFunc_ff, nxt_diFunc;
	logic [IRQ_W-1:0] irqMask_ff, nxt_irqMask;

	always_comb begin
		nxt_setOne = setOne_ff;
		nxt_setTwo = setTwo_ff;
		nxt_switchCond = switchCond_ff;
		nxt_thrLow = thrLow_ff;
		nxt_thrHigh = thrHigh_ff;
		nxt_startValue = startValue_ff;
		nxt_holdTime = holdTime_ff;
		nxt_intAttr = intAttr_ff;
		nxt_lossThr = lossThr_ff;
		nxt_lossTime = lossTime_ff;
		nxt_stopOp = stopOp_ff;
		nxt_diFunc = diFunc_ff;
		nxt_irqMask = irqMask_ff;
		if (regWrite) begin
			unique case (regAddr)
				REG_PGAIN_ONE: nxt_setOne.kp = regWrData;
				REG_TI1: nxt_setOne.ti = regWrData;
				REG_TD1: nxt_setOne.td = regWrData;
				REG_PGAIN_TWO: nxt_setTwo.kp = regWrData;
				REG_TI2: nxt_setTwo.ti = regWrData;
				REG_TD2: nxt_setTwo.td = regWrData;
				REG_SWITCH_COND: nxt_switchCond = regWrData[1:0];
				REG_THR_LOW: nxt_thrLow = regWrData;
				REG_THR_HIGH: nxt_thrHigh = regWrData;
				REG_STARTUP_VALUE: nxt_startValue = regWrData;
				REG_STARTUP_HOLD: nxt_holdTime = regWrData;
				REG_INT_ATTR: nxt_intAttr = regWrData[7:0];
				REG_LOSS_THR: nxt_lossThr = regWrData;
				REG_LOSS_TIME: nxt_lossTime = regWrData;
				REG_STOP_OP: nxt_stopOp = regWrData[0];
				REG_IRQ_MASK: nxt_irqMask = regWrData[IRQ_W-1:0];
				default: begin
					for (int i = 0; i < DI_COUNT; i++) begin
						if (regAddr == 5'(REG_DI_FUNC0 + 5'(i))) begin
							nxt_diFunc[i*8 +: 8] = regWrData[7:0];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			setOne_ff <= '{RST_PGAIN_ONE, RST_TI1, RST_TD1};
			setTwo_ff <= '{RST_PGAIN_TWO, RST_TI2, RST_TD2};
			switchCond_ff <= RST_SWITCH_COND;
			thrLow_ff <= RST_THR_LOW;
			thrHigh_ff <= RST_THR_HIGH;
			startValue_ff <= RST_STARTUP_VALUE;
			holdTime_ff <= RST_STARTUP_HOLD;
			intAttr_ff <= RST_INT_ATTR;
			lossThr_ff <= RST_LOSS_THR;
			lossTime_ff <= RST_LOSS_TIME;
			stopOp_ff <= RST_STOP_OP;
			diFunc_ff <= '0;
			irqMask_ff <= '0;
		end else begin
			setOne_ff <= nxt_setOne;
			setTwo_ff <= nxt_setTwo;
			switchCond_ff <= nxt_switchCond;
			thrLow_ff <= nxt_thrLow;
			thrHigh_ff <= nxt_thrHigh;
			startValue_ff <= nxt_startValue;
			holdTime_ff <= nxt_holdTime;
			intAttr_ff <= nxt_intAttr;
			lossThr_ff <= nxt_lossThr;
			lossTime_ff <= nxt_lossTime;
			stopOp_ff <= nxt_stopOp;
			diFunc_ff <= nxt_diFunc;
			irqMask_ff <= nxt_irqMask;
		end
	end

	////////////////////////////////////////////////////////////////////
	// gain set selection
	logic [15:0] deviation;
	logic gainSelectIn;
	logic pauseIn;
	logic sepEnable;
	logic limitStop;
	gain_set_t nxt_gains;
	gain_set_t gains_ff;

	always_comb begin
		deviation = (setpoint >= feedback) ? 16'(setpoint - feedback) :
			16'(feedback - setpoint);
		gainSelectIn = diActive(diLevels, diFunc_ff, FUNC_GAIN_SELECT);
		pauseIn = diActive(diLevels, diFunc_ff, FUNC_INTEGRAL_PAUSE);
		sepEnable = (intAttr_ff % DECIMAL_BASE) == 8'h01;
		limitStop = ((intAttr_ff / DECIMAL_BASE) % DECIMAL_BASE) == 8'h01;
		nxt_gains = setOne_ff;
		unique case (switchCond_ff)
			COND_TERMINAL: begin
				nxt_gains = gainSelectIn ? setTwo_ff : setOne_ff;
			end
			COND_AUTO: begin
				if (deviation < thrLow_ff) begin
					nxt_gains = setOne_ff;
				end else if (deviation > thrHigh_ff ||
						thrHigh_ff <= thrLow_ff) begin
					// an empty band degenerates to a hard switch
					nxt_gains = setTwo_ff;
				end else begin
					nxt_gains.kp = lerp(setOne_ff.kp, setTwo_ff.kp,
						16'(deviation - thrLow_ff),
						16'(thrHigh_ff - thrLow_ff));
					nxt_gains.ti = lerp(setOne_ff.ti, setTwo_ff.ti,
						16'(deviation - thrLow_ff),
						16'(thrHigh_ff - thrLow_ff));
					nxt_gains.td = lerp(setOne_ff.td, setTwo_ff.td,
						16'(deviation - thrLow_ff),
						16'(thrHigh_ff - thrLow_ff));
				end
			end
			default: nxt_gains = setOne_ff;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// base tick divider
	logic [31:0] divCount_ff, nxt_divCount;
	logic tick;

	always_comb begin
		tick = divCount_ff == 32'(TICK_CYCLES - 1);
		nxt_divCount = tick ? 32'h00000000 : 32'(divCount_ff + 32'h00000001);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			divCount_ff <= '0;
		end else begin
			divCount_ff <= nxt_divCount;
		end
	end

	////////////////////////////////////////////////////////////////////
	// startup hold sequence and feedback loss timer
	loop_state_t state_ff, nxt_state;
	logic [15:0] holdCount_ff, nxt_holdCount;
	logic [19:0] lossCount_ff, nxt_lossCount;
	logic holdDone;
	logic lossDetect;

	always_comb begin
		nxt_state = state_ff;
		nxt_holdCount = holdCount_ff;
		holdDone = 1'b0;
		if (driveStart) begin
			nxt_state = ST_HOLD;
			nxt_holdCount = '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: nxt_state = ST_IDLE;
				ST_HOLD: begin
					if (holdCount_ff >= holdTime_ff) begin
						nxt_state = ST_REGULATE;
						holdDone = 1'b1;
					end else if (tick && driveRunning) begin
						nxt_holdCount = 16'(holdCount_ff + 16'h0001);
					end
				end
				ST_REGULATE: nxt_state = ST_REGULATE;
				default: nxt_state = ST_IDLE;
			endcase
		end
		lossDetect = 1'b0;
		if (lossThr_ff == 16'h0000 || feedback >= lossThr_ff) begin
			nxt_lossCount = '0;
		end else begin
			nxt_lossCount = lossCount_ff;
			if (lossCount_ff > 20'(lossTime_ff * LOSS_TICKS_PER_UNIT)) begin
				lossDetect = 1'b1;
			end else if (tick) begin
				nxt_lossCount = 20'(lossCount_ff + 20'h00001);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			holdCount_ff <= '0;
			lossCount_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			holdCount_ff <= nxt_holdCount;
			lossCount_ff <= nxt_lossCount;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, interrupts and read port
	logic [IRQ_W-1:0] irqStatus_ff, nxt_irqStatus;
	logic nxt_force;
	logic nxt_compute;
	logic nxt_freeze;
	logic nxt_fault;
	logic nxt_irq;
	logic [15:0] nxt_rdData;
	logic [IRQ_W-1:0] events;

	always_comb begin
		events = '0;
		events[IRQ_LOSS_BIT] = lossDetect;
		events[IRQ_HOLD_DONE_BIT] = holdDone;
		nxt_irqStatus = irqStatus_ff;
		if (regRead && regAddr == REG_IRQ_STATUS) begin
			nxt_irqStatus = '0;
		end
		// a new event in the clearing cycle survives
		nxt_irqStatus = nxt_irqStatus | events;
		nxt_irq = |(nxt_irqStatus & irqMask_ff);
		// force and compute follow one state, so they never overlap
		nxt_force = nxt_state == ST_HOLD;
		nxt_compute = nxt_state == ST_REGULATE && (driveRunning || stopOp_ff);
		nxt_freeze = (sepEnable && pauseIn) || (limitStop && outputAtLimit);
		// fault latches until reset; no other input of this module clears it
		nxt_fault = feedbackLossFault | lossDetect;
		nxt_rdData = '0;
		unique case (regAddr)
			REG_PGAIN_ONE: nxt_rdData = setOne_ff.kp;
			REG_TI1: nxt_rdData = setOne_ff.ti;
			REG_TD1: nxt_rdData = setOne_ff.td;
			REG_PGAIN_TWO: nxt_rdData = setTwo_ff.kp;
			REG_TI2: nxt_rdData = setTwo_ff.ti;
			REG_TD2: nxt_rdData = setTwo_ff.td;
			REG_SWITCH_COND: nxt_rdData = {14'h0000, switchCond_ff};
			REG_THR_LOW: nxt_rdData = thrLow_ff;
			REG_THR_HIGH: nxt_rdData = thrHigh_ff;
			REG_STARTUP_VALUE: nxt_rdData = startValue_ff;
			REG_STARTUP_HOLD: nxt_rdData = holdTime_ff;
			REG_INT_ATTR: nxt_rdData = {8'h00, intAttr_ff};
			REG_LOSS_THR: nxt_rdData = lossThr_ff;
			REG_LOSS_TIME: nxt_rdData = lossTime_ff;
			REG_STOP_OP: nxt_rdData = {15'h0000, stopOp_ff};
			REG_STATE: nxt_rdData = {12'h000, feedbackLossFault,
				integratorFreeze, state_ff};
			REG_IRQ_STATUS: nxt_rdData = {14'h0000, irqStatus_ff};
			REG_IRQ_MASK: nxt_rdData = {14'h0000, irqMask_ff};
			default: begin
				for (int i = 0; i < DI_COUNT; i++) begin
					if (regAddr == 5'(REG_DI_FUNC0 + 5'(i))) begin
						nxt_rdData = {8'h00, diFunc_ff[i*8 +: 8]};
					end
				end
			end
		endcase
		if (!regRead) begin
			nxt_rdData = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irqStatus_ff <= '0;
			gains_ff <= '{RST_PGAIN_ONE, RST_TI1, RST_TD1};
			outputForce <= 1'b0;
			forcedOutput <= RST_STARTUP_VALUE;
			loopCompute <= 1'b0;
			integratorFreeze <= 1'b0;
			feedbackLossFault <= 1'b0;
			faultCode <= 8'h00;
			irq <= 1'b0;
			regRdData <= '0;
		end else begin
			irqStatus_ff <= nxt_irqStatus;
			gains_ff <= nxt_gains;
			outputForce <= nxt_force;
			forcedOutput <= startValue_ff;
			loopCompute <= nxt_compute;
			integratorFreeze <= nxt_freeze;
			feedbackLossFault <= nxt_fault;
			faultCode <= nxt_fault ? FAULT_FEEDBACK_LOSS : 8'h00;
			irq <= nxt_irq;
			regRdData <= nxt_rdData;
		end
	end

	assign activeGains = gains_ff;

endmodule
`default_nettype wire

//--- testbench/pid_supervisor_sva.sv
// Purpose: port checks of the gain switch supervisor
// Assumes: one clock, synchronous reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module pid_supervisor_sva
	import pid_supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic [15:0] setpoint,
	input wire logic [15:0] feedback,
	input wire logic driveStart,
	input wire logic [DI_COUNT-1:0] diLevels,
	input wire pid_supervisor_pkg::gain_set_t activeGains,
	input wire logic outputForce,
	input wire logic loopCompute,
	input wire logic feedbackLossFault,
	input wire logic [7:0] faultCode
);
default clocking cb @(posedge clock); endclocking
default disable iff (reset);
//////////////////////////////////////////
property p_start_force;
	driveStart |=> outputForce;
endproperty
a_start_force: assert property (p_start_force)
	else $error("output not forced after start");
property p_force_origin;
	$rose(outputForce) |-> $past(driveStart);
endproperty
a_force_origin: assert property (p_force_origin)
	else $error("force began without a start");
property p_force_no_compute;
	outputForce |-> !loopCompute;
endproperty
a_force_no_compute: assert property (p_force_no_compute)
	else $error("loop computes during hold");
property p_fault_code;
	feedbackLossFault |-> faultCode == FAULT_FEEDBACK_LOSS;
endproperty
a_fault_code: assert property (p_fault_code)
	else $error("wrong fault code");
property p_no_fault_code;
	!feedbackLossFault |-> faultCode == 8'h00;
endproperty
a_no_fault_code: assert property (p_no_fault_code)
	else $error("fault code without fault");
property p_fault_sticky;
	feedbackLossFault |=> feedbackLossFault;
endproperty
a_fault_sticky: assert property (p_fault_sticky)
	else $error("fault dropped without reset");
property p_gain_hold;
	(!regWrite && $stable(setpoint) && $stable(feedback)
		&& $stable(diLevels)) [*2] |=> $stable(activeGains);
endproperty
a_gain_hold: assert property (p_gain_hold)
	else $error("gains moved with steady inputs");
property p_rd_idle;
	!regRead |=> regRdData == 16'h0000;
endproperty
a_rd_idle: assert property (p_rd_idle)
	else $error("read data outside read slot");
endmodule
bind pid_gain_switch_supervisor pid_supervisor_sva u_sva (.clock, .reset,
	.regWrite, .regRead, .regRdData, .setpoint, .feedback, .driveStart,
	.diLevels, .activeGains, .outputForce, .loopCompute,
	.feedbackLossFault, .faultCode);
`default_nettype wire

//--- testbench/drive_model.sv
// Purpose: drive side that issues start events and the running level
// Assumes: run request from the bench, synchronous to clock
// Notes: start is a one-cycle pulse on each rise of the request
`timescale 1ns/1ns
`default_nettype none
module drive_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic runReq,
	output logic driveStart,
	output logic driveRunning
);
	logic runReq_ff;
	//////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (reset) begin
			runReq_ff <= 1'b0;
			driveStart <= 1'b0;
			driveRunning <= 1'b0;
		end else begin
			runReq_ff <= runReq;
			driveStart <= runReq && !runReq_ff;
			driveRunning <= runReq;
		end
	end
endmodule
`default_nettype wire

//--- testbench/test_pid_gain_switch_supervisor.sv
// Purpose: self-checking bench of the gain switch supervisor
// Assumes: tick shortened to 4 clocks
// Notes: random gains and deviations, corners from tables
`timescale 1ns/1ns
`default_nettype none
module test_pid_gain_switch_supervisor;
	import pid_supervisor_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] setpoint = '0;
	logic [15:0] feedback = '0;
	logic runReq = 1'b0;
	logic outputAtLimit = 1'b0;
	logic [DI_COUNT-1:0] diLevels = '0;
	logic [DATA_W-1:0] regRdData;
	logic driveStart, driveRunning, outputForce, loopCompute;
	logic integratorFreeze, feedbackLossFault, irq, sel;
	logic [15:0] forcedOutput, rdVal;
	logic [15:0] gv [6];
	logic [7:0] faultCode;
	gain_set_t activeGains, g1, g2;
	int mismatches = 0;
	int numChecks = 0;
	int cnt, dev;
	int devTab [6] = '{0, 199, 200, 500, 800, 801};
	int attrTab [6] = '{1, 0, 10, 1, 11, 10};
	pid_gain_switch_supervisor #(.TICK_CYCLES(4)) u_dut (.clock(clock),
		.reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.setpoint(setpoint), .feedback(feedback),
		.driveRunning(driveRunning), .driveStart(driveStart),
		.outputAtLimit(outputAtLimit), .diLevels(diLevels),
		.activeGains(activeGains), .outputForce(outputForce),
		.forcedOutput(forcedOutput), .loopCompute(loopCompute),
		.integratorFreeze(integratorFreeze),
		.feedbackLossFault(feedbackLossFault), .faultCode(faultCode),
		.irq(irq));
	drive_model u_drive (.clock(clock), .reset(reset), .runReq(runReq),
		.driveStart(driveStart), .driveRunning(driveRunning));
	//////////////////////////////////////////
	task automatic chk(input string what, input logic [47:0] seen,
			input logic [47:0] exp);
		numChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// truncates toward zero, as the interpolator does
	function automatic logic [15:0] lerp(input logic [15:0] a,
			input logic [15:0] b, input int d);
		int lo = int'(RST_THR_LOW);
		return 16'(int'(a) + (int'(b) - int'(a)) * (d - lo)
			/ (int'(RST_THR_HIGH) - lo));
	endfunction
	function automatic gain_set_t expG(input int c, input logic s,
			input int d);
		if (c == int'(COND_TERMINAL) && s) return g2;
		if (c != int'(COND_AUTO) || d < int'(RST_THR_LOW)) return g1;
		if (d > int'(RST_THR_HIGH)) return g2;
		return {lerp(g1.kp, g2.kp, d), lerp(g1.ti, g2.ti, d),
			lerp(g1.td, g2.td, d)};
	endfunction
	//////////////////////////////////////////
	initial begin
		forever #2 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		test_done();
	end
	initial begin
		void'($urandom(4));
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		cyc(2);
		chk("gainsRst", activeGains,
			{RST_PGAIN_ONE, RST_TI1, RST_TD1});
		chk("startVal", forcedOutput, RST_STARTUP_VALUE);
		rd(REG_STOP_OP, rdVal);
		chk("stopOpRst", rdVal, 16'(RST_STOP_OP));
		rd(5'h1F, rdVal);
		chk("unmapped", rdVal, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			gv[i] = 16'($urandom_range(1000));
			wr(5'(i), gv[i]);
		end
		g1 = {gv[0], gv[1], gv[2]};
		g2 = {gv[3], gv[4], gv[5]};
		wr(REG_DI_FUNC0, 16'(FUNC_GAIN_SELECT));
		wr(REG_DI_FUNC0 + 5'h01, 16'(FUNC_INTEGRAL_PAUSE));
		for (int c = 0; c < 4; c++) begin
			wr(REG_SWITCH_COND, 16'(c));
			for (int k = 0; k < 12; k++) begin
				dev = k < 6 ? devTab[k] : int'($urandom_range(1000));
				sel = 1'($urandom_range(1));
				@(posedge clock);
				setpoint <= (k % 2) ? 16'(dev) : 16'h0000;
				feedback <= (k % 2) ? 16'h0000 : 16'(dev);
				diLevels[0] <= sel;
				diLevels[1] <= 1'($urandom_range(1));
				cyc(3);
				chk("gains", activeGains, expG(c, sel, dev));
			end
		end
		$display("test gains done");
		wr(REG_STARTUP_HOLD, 16'h0002);
		wr(REG_IRQ_MASK, 16'h0003);
		wr(REG_STARTUP_VALUE, 16'h0123);
		cyc(2);
		chk("startSet", forcedOutput, 16'h0123);
		@(posedge clock);
		runReq <= 1'b1;
		for (cnt = 0; cnt < 20 && outputForce !== 1'b1; cnt++) cyc(1);
		chk("forceOn", outputForce, 1'b1);
		chk("noCompute", loopCompute, 1'b0);
		for (cnt = 0; cnt < 40 && outputForce === 1'b1; cnt++) cyc(1);
		chk("holdLen", cnt >= 4 && cnt <= 13, 1'b1);
		cyc(2);
		chk("regulate", {loopCompute, irq}, 2'h3);
		rd(REG_IRQ_STATUS, rdVal);
		chk("holdIrq", rdVal, 16'h0002);
		cyc(2);
		chk("irqClear", irq, 1'b0);
		@(posedge clock);
		runReq <= 1'b0;
		wr(REG_STOP_OP, 16'h0000);
		cyc(3);
		chk("stopHalt", loopCompute, 1'b0);
		wr(REG_STOP_OP, 16'h0001);
		cyc(3);
		chk("stopRun", loopCompute, 1'b1);
		$display("test start done");
		for (int k = 0; k < 6; k++) begin
			wr(REG_INT_ATTR, 16'(attrTab[k]));
			@(posedge clock);
			diLevels[1] <= 1'(6'h13 >> k);
			outputAtLimit <= 1'(6'h0C >> k);
			cyc(3);
			chk("freeze", integratorFreeze, 1'(6'h15 >> k));
		end
		$display("test integrator done");
		@(posedge clock);
		feedback <= 16'h0000;
		cyc(100);
		chk("lossOff", feedbackLossFault, 1'b0);
		wr(REG_LOSS_TIME, 16'h0001);
		wr(REG_LOSS_THR, 16'h01F4);
		@(posedge clock);
		feedback <= 16'h0064;
		cyc(30);
		@(posedge clock);
		feedback <= 16'h0258;
		cyc(2);
		@(posedge clock);
		feedback <= 16'h0064;
		cyc(30);
		chk("lossClear", feedbackLossFault, 1'b0);
		for (cnt = 0; cnt < 60 && feedbackLossFault !== 1'b1; cnt++) cyc(1);
		chk("loss", {feedbackLossFault, faultCode}, 9'h11F);
		cyc(2);
		chk("lossIrq", irq, 1'b1);
		$display("test loss done");
		test_done();
	end
endmodule
`default_nettype wire
